// *** sim/flash_device_model.sv ***
`timescale 1ns/100ps
module flash_device_model #(
  parameter logic [7:0] MAKER_CODE = 8'h5C, // Arbitrary value
  parameter logic [7:0] PART_CODE  = 8'hC3, // Arbitrary value
  parameter int         PROG_NS    = 2000,
  parameter int         ERASE_NS   = 20000,
  parameter int         ABORT_NS   = 10000
) (
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic [15:0] addr,
  input  wire logic [7:0]  dq_i,
  output logic [7:0]       dq_o,
  output logic             dq_drive
);
  logic [7:0]  mem [0:65535];
  logic [7:0]  rd, pd_q;
  logic [15:0] wa_q;
  logic [2:0]  step_q;
  logic        id_q, byp_q, busy_q, err_q, erase_q, tog_q;
  int          gen_q;

  // Contents read as zero until the first erase
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
    {pd_q, step_q, id_q, byp_q, busy_q, err_q, erase_q, tog_q} = '0;
    gen_q = 0;
  end

  // Status word wins over array and id codes while busy or failed
  always_comb begin
    if (busy_q || err_q) rd = {!erase_q && !pd_q[7], tog_q, err_q, 5'h00};
    else if (id_q) rd = addr[1] ? 8'h00 : addr[0] ? PART_CODE : MAKER_CODE;
    else rd = mem[addr];
  end
  assign dq_drive = !ce_n && !oe_n;
  assign #45 dq_o = rd;

  // One flip per read cycle; waits for chip select, which falls alongside
  always @(negedge oe_n)
    #1 if (!ce_n && (busy_q || err_q)) tog_q = ~tog_q;

  // Address on the later fall, data on the earlier rise
  always @(negedge we_n) if (!ce_n) wa_q = addr;
  always @(posedge we_n) if (!ce_n) bus_write(wa_q, dq_i);

  task automatic finish_op(input int g, input int ns, input bit fail);
    #(ns);
    if (g == gen_q) begin
      if (fail) err_q = 1'b1;
      else busy_q = 1'b0;
    end
  endtask : finish_op

  task automatic start(input bit er, input logic [15:0] ta, input logic [7:0] td);
    logic fail;
    fail = !er && ((~mem[ta] & td) != 8'h00);
    busy_q = 1'b1;
    erase_q = er;
    pd_q = td;
    gen_q++;
    if (er) foreach (mem[i]) mem[i] = 8'hFF;
    else if (!fail) mem[ta] = td;
    fork finish_op(gen_q, er ? ERASE_NS : PROG_NS, fail); join_none
  endtask : start

  task automatic bus_write(input logic [15:0] a, input logic [7:0] d);
    logic u1, u2;
    logic [2:0] nx;
    u1 = a[10:0] == 11'h555;
    u2 = a[10:0] == 11'h2AA;
    nx = 3'd0;
    if (err_q) begin
      if (d == 8'hF0) {err_q, busy_q, step_q} = '0;
    end else if (busy_q) begin
      if (erase_q && d == 8'hF0) begin
        gen_q++;
        fork finish_op(gen_q, ABORT_NS, 1'b0); join_none
      end
    end else if (byp_q) begin
      if (step_q == 3'd1) start(1'b0, a, d);
      if (step_q == 3'd2 && d == 8'h00) byp_q = 1'b0;
      if (step_q == 3'd0) nx = d == 8'hA0 ? 3'd1 : d == 8'h90 ? 3'd2 : 3'd0;
      step_q = nx;
    end else begin
      case (step_q)
        3'd0: nx = (u1 && d == 8'hAA) ? 3'd1 : 3'd0;
        3'd1: nx = (u2 && d == 8'h55) ? 3'd2 : 3'd0;
        3'd2: nx = !u1 ? 3'd0 : d == 8'hA0 ? 3'd3 : d == 8'h80 ? 3'd4 : 3'd0;
        3'd3: start(1'b0, a, d);
        3'd4: nx = (u1 && d == 8'hAA) ? 3'd5 : 3'd0;
        3'd5: nx = (u2 && d == 8'h55) ? 3'd6 : 3'd0;
        default: if (u1 && d == 8'h10) start(1'b1, a, d);
      endcase
      byp_q = step_q == 3'd2 && u1 && d == 8'h20;
      if (nx == 3'd0) id_q = step_q == 3'd2 && u1 && d == 8'h90;
      step_q = nx;
    end
  endtask : bus_write
endmodule : flash_device_model

// *** sim/flash_host_test.sv ***
`timescale 1ns/100ps
module flash_host_test;
  import flash_host_pkg::*;
  typedef struct {logic [7:0] d; logic e; bit cd;} exp_s;
  localparam logic [7:0] MAKER = 8'h5C; // Arbitrary value
  localparam logic [7:0] PART  = 8'hC3; // Arbitrary value
  logic        core_clk = 0, rstn = 0, cmd_valid = 0;
  op_e         cmd_op = OP_READ;
  logic [15:0] cmd_addr = '0, flash_addr, a, b, hi;
  logic [7:0]  cmd_data = '0, rsp_data, data_lines_o, data_lines_i;
  logic [7:0]  dev_dq, d;
  logic        cmd_ready, rsp_valid, rsp_err, busy, bypass_mode, id_mode;
  logic        flash_ce_n, flash_oe_n, flash_we_n, data_lines_oe_n;
  logic        dev_drive;
  logic [31:0] rnd = 32'he30e;
  int          failures = 0, cmp_count = 0, cyc = 0;
  exp_s        exp_q[$], e;

  always #20 core_clk = ~core_clk;

  // Nobody drives: lines show garbage, never the last value
  assign data_lines_i = !data_lines_oe_n ? data_lines_o :
                        dev_drive ? dev_dq : ~data_lines_o;

  flash_host flash_host_inst (.core_clk(core_clk), .rstn(rstn),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
    .cmd_addr(cmd_addr), .cmd_data(cmd_data), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_err(rsp_err), .busy(busy),
    .bypass_mode(bypass_mode), .id_mode(id_mode), .flash_ce_n(flash_ce_n),
    .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
    .flash_addr(flash_addr), .data_lines_o(data_lines_o),
    .data_lines_oe_n(data_lines_oe_n), .data_lines_i(data_lines_i));

  flash_device_model #(.MAKER_CODE(MAKER), .PART_CODE(PART))
    flash_device_model_inst (.ce_n(flash_ce_n), .oe_n(flash_oe_n),
    .we_n(flash_we_n), .addr(flash_addr), .dq_i(data_lines_i),
    .dq_o(dev_dq), .dq_drive(dev_drive));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  task automatic check(input string n, input logic [7:0] s, x);
    cmp_count++;
    if (s !== x) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, x, s);
    end
  endtask : check

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results

  // Hold the request until taken, then wait for its answer
  task automatic cmd(input op_e op, input logic [15:0] ad,
                     input logic [7:0] dt, xd, input logic xe, input bit cd);
    exp_q.push_back('{xd, xe, cd});
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_addr <= ad;
    cmd_data <= dt;
    @(negedge core_clk);
    while (cmd_ready !== 1'b1) @(negedge core_clk);
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    @(negedge core_clk);
    while (rsp_valid !== 1'b1) @(negedge core_clk);
  endtask : cmd

  // Each answer is matched against the oldest note
  always @(posedge core_clk) begin
    if (rsp_valid === 1'b1) begin
      if (exp_q.size() == 0) check("rsp count", 8'h01, 8'h00);
      else begin
        e = exp_q.pop_front();
        if (e.cd) check("rsp_data", rsp_data, e.d);
        check("rsp_err", rsp_err, e.e);
      end
      check("busy", busy, 8'h00);
    end
  end

  // Hang guard, far above the longest erase and polling
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      results();
    end
  end

  initial begin
    repeat (6) @(posedge core_clk);
    rstn <= 1'b1;
    rnd = lfsr(lfsr(rnd));
    a = rnd[15:0];
    b = a ^ 16'h0100;
    d = rnd[23:16] & 8'hFE; // Bit zero low so a write of FF must fail
    hi = rnd[31:16];
    // Erase cut short by a reset before its first poll; only the reset answers
    exp_q.push_back('{8'h00, 1'b1, 1'b0});
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd_op <= OP_ERASE;
    @(negedge core_clk);
    while (cmd_ready !== 1'b1) @(negedge core_clk);
    @(posedge core_clk);
    cmd_op <= OP_RESET;
    @(negedge core_clk);
    while (cmd_ready !== 1'b1) @(negedge core_clk);
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    @(negedge core_clk);
    check("busy", busy, 8'h01);
    while (rsp_valid !== 1'b1) @(negedge core_clk);
    cmd(OP_ERASE, 0, 0, 8'hFF, 0, 1);
    cmd(OP_READ, a, 0, 8'hFF, 0, 1);
    cmd(OP_PROGRAM, a, d, d, 0, 1);
    cmd(OP_READ, a, 0, d, 0, 1);
    cmd(OP_PROGRAM, a, 8'hFF, 0, 1, 0);
    cmd(OP_READ, a, 0, d, 0, 1);
    for (int i = 0; i < 2; i++) begin
      cmd(OP_AUTOSEL, 0, 0, 0, 0, 0);
      check("id_mode", id_mode, 8'h01);
      cmd(OP_READ, {hi[15:2], 2'b00}, 0, MAKER, 0, 1);
      cmd(OP_READ, {hi[15:2], 2'b01}, 0, PART, 0, 1);
      cmd(i ? OP_RESET3 : OP_RESET, 0, 0, 0, 0, 0);
      check("id_mode", id_mode, 8'h00);
      cmd(OP_READ, a, 0, d, 0, 1);
    end
    cmd(OP_BYPASS, 0, 0, 0, 0, 0);
    check("bypass_mode", bypass_mode, 8'h01);
    cmd(OP_PROGRAM, b, d, 0, 1, 0);
    cmd(OP_BYP_PROG, b, d, d, 0, 1);
    cmd(OP_READ, b, 0, d, 0, 1);
    cmd(OP_BYP_PROG, b, 8'hFF, 0, 1, 0);
    check("bypass_mode", bypass_mode, 8'h01);
    cmd(OP_BYP_EXIT, 0, 0, 0, 0, 0);
    check("bypass_mode", bypass_mode, 8'h00);
    cmd(OP_BYP_PROG, b, d, 0, 1, 0);
    repeat (4) @(posedge core_clk);
    results();
  end
endmodule : flash_host_test

// *** verilog/flash_bus_cycle.sv ***
`timescale 1ns/100ps
module flash_bus_cycle #(
  parameter int ADDR_W = 16
) (
  input  wire logic              core_clk,
  input  wire logic              rstn,
  flash_bus_if.cycle             bus,
  output logic                   flash_ce_n,
  output logic                   flash_oe_n,
  output logic                   flash_we_n,
  output logic [ADDR_W-1:0]      flash_addr,
  output logic [7:0]             data_lines_o,
  output logic                   data_lines_oe_n,
  input  wire logic [7:0]        data_lines_i
);
  import flash_host_pkg::*;

  typedef enum logic [2:0] {C_IDLE, C_SETUP, C_STROBE, C_RELEASE, C_READ}
    cyc_e;

  cyc_e              st_q, st_d;
  logic [3:0]        cnt_q, cnt_d;
  logic              ce_q, ce_d, oe_q, oe_d, we_q, we_d, drv_q, drv_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [7:0]        wd_q, wd_d, rd_q, rd_d;
  logic              done_q, done_d;

  // Strobe sequencing: chip select first, write strobe inside it
  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    ce_d   = ce_q;
    oe_d   = oe_q;
    we_d   = we_q;
    drv_d  = drv_q;
    addr_d = addr_q;
    wd_d   = wd_q;
    rd_d   = rd_q;
    done_d = 1'b0;
    case (st_q)
      C_IDLE: begin
        if (bus.req) begin
          addr_d = bus.addr;
          wd_d   = bus.wdata;
          ce_d   = 1'b0;
          if (bus.wr) begin
            drv_d = 1'b0;
            st_d  = C_SETUP;
          end else begin
            oe_d  = 1'b0;
            cnt_d = 4'(ACC_CYC);
            st_d  = C_READ;
          end
        end
      end
      C_SETUP: begin
        // Strobe falls last, so the address is taken on it
        we_d  = 1'b0;
        cnt_d = 4'(WP_CYC - 1);
        st_d  = C_STROBE;
      end
      C_STROBE: begin
        if (cnt_q == 4'h0) begin
          we_d = 1'b1;
          st_d = C_RELEASE;
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      C_RELEASE: begin
        // Strobe rose first, so data is held one more cycle past it
        ce_d   = 1'b1;
        drv_d  = 1'b1;
        done_d = 1'b1;
        st_d   = C_IDLE;
      end
      C_READ: begin
        if (cnt_q == 4'h0) begin
          rd_d   = data_lines_i;
          ce_d   = 1'b1;
          oe_d   = 1'b1;
          done_d = 1'b1;
          st_d   = C_IDLE;
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      default: st_d = C_IDLE;
    endcase
  end

  // Pin and state registers
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_q   <= C_IDLE;
      cnt_q  <= 4'h0;
      ce_q   <= 1'b1;
      oe_q   <= 1'b1;
      we_q   <= 1'b1;
      drv_q  <= 1'b1;
      addr_q <= '0;
      wd_q   <= 8'h00;
      rd_q   <= 8'h00;
      done_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      ce_q   <= ce_d;
      oe_q   <= oe_d;
      we_q   <= we_d;
      drv_q  <= drv_d;
      addr_q <= addr_d;
      wd_q   <= wd_d;
      rd_q   <= rd_d;
      done_q <= done_d;
    end
  end

  assign flash_ce_n      = ce_q;
  assign flash_oe_n      = oe_q;
  assign flash_we_n      = we_q;
  assign flash_addr      = addr_q;
  assign data_lines_o    = wd_q;
  assign data_lines_oe_n = drv_q;
  assign bus.rdata       = rd_q;
  assign bus.done        = done_q;

  // Write strobe pulse framed by chip select on both sides
  sequence s_strobe_low;
    !we_q && !ce_q && !drv_q;
  endsequence

  a_we_inside_ce: assert property (@(posedge core_clk) disable iff (!rstn)
    $fell(we_q) |-> !$past(ce_q) ##0 s_strobe_low [*2] ##1 we_q && !ce_q)
    else $error("write strobe not framed by chip select");
  a_oe_off_write: assert property (@(posedge core_clk) disable iff (!rstn)
    !we_q |-> oe_q && !drv_q)
    else $error("output enable low or data undriven in write");
  a_read_no_drive: assert property (@(posedge core_clk) disable iff (!rstn)
    !oe_q |-> drv_q && we_q && !ce_q)
    else $error("host drives data lines during a read");
endmodule : flash_bus_cycle

// *** verilog/flash_bus_if.sv ***
`timescale 1ns/100ps
interface flash_bus_if #(parameter int ADDR_W = 16);
  logic              req;
  logic              wr;
  logic [ADDR_W-1:0] addr;
  logic [7:0]        wdata;
  logic [7:0]        rdata;
  logic              done;

  modport master (output req, wr, addr, wdata, input rdata, done);
  modport cycle  (input req, wr, addr, wdata, output rdata, done);
endinterface : flash_bus_if

// *** verilog/flash_host.sv ***
`timescale 1ns/100ps
module flash_host #(
  parameter int ADDR_W = 16
) (
  input  wire logic                  core_clk,
  input  wire logic                  rstn,
  input  wire logic                  cmd_valid,
  output logic                       cmd_ready,
  input  wire flash_host_pkg::op_e   cmd_op,
  input  wire logic [ADDR_W-1:0]     cmd_addr,
  input  wire logic [7:0]            cmd_data,
  output logic                       rsp_valid,
  output logic [7:0]                 rsp_data,
  output logic                       rsp_err,
  output logic                       busy,
  output logic                       bypass_mode,
  output logic                       id_mode,
  output logic                       flash_ce_n,
  output logic                       flash_oe_n,
  output logic                       flash_we_n,
  output logic [ADDR_W-1:0]          flash_addr,
  output logic [7:0]                 data_lines_o,
  output logic                       data_lines_oe_n,
  input  wire logic [7:0]            data_lines_i
);
  import flash_host_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE, S_ISSUE, S_WAIT, S_POLL_ISSUE, S_POLL_WAIT, S_ABORT
  } state_e;

  flash_bus_if #(.ADDR_W(ADDR_W)) bus_i ();

  flash_bus_cycle #(.ADDR_W(ADDR_W)) u_cycle (
    .core_clk        (core_clk),
    .rstn            (rstn),
    .bus             (bus_i.cycle),
    .flash_ce_n      (flash_ce_n),
    .flash_oe_n      (flash_oe_n),
    .flash_we_n      (flash_we_n),
    .flash_addr      (flash_addr),
    .data_lines_o    (data_lines_o),
    .data_lines_oe_n (data_lines_oe_n),
    .data_lines_i    (data_lines_i)
  );

  state_e            state_q, state_d;
  op_e               op_q, op_d;
  logic [2:0]        step_q, step_d;
  logic [ADDR_W-1:0] tgt_addr_q, tgt_addr_d;
  logic [7:0]        tgt_data_q, tgt_data_d;
  logic [7:0]        prev_q, prev_d;
  logic [1:0]        poll_n_q, poll_n_d;
  logic [8:0]        cnt_q, cnt_d;
  logic              bypass_q, bypass_d, idm_q, idm_d;
  logic              abort_q, abort_d, fail_q, fail_d;
  logic              rsp_valid_q, rsp_valid_d, rsp_err_q, rsp_err_d;
  logic [7:0]        rsp_data_q, rsp_data_d;
  logic [ADDR_W+7:0] cur_word;
  logic              refused, last_step, prog_type, toggled, abort_take;

  // Address and data of one write of a command sequence
  function automatic logic [ADDR_W+7:0] step_word(input op_e op,
      input logic [2:0] idx, input logic [ADDR_W-1:0] ta,
      input logic [7:0] td);
    logic [10:0] ca;
    logic [7:0]  cd;
    logic        use_tgt;
    ca      = 11'h000;
    cd      = CODE_RESET;
    use_tgt = 1'b0;
    case (op)
      OP_READ:     use_tgt = 1'b1;
      OP_RESET:    cd = CODE_RESET;
      OP_BYP_PROG: begin
        if (idx == 3'h0) cd = CODE_PROGRAM;
        else use_tgt = 1'b1;
      end
      OP_BYP_EXIT: cd = (idx == 3'h0) ? CODE_AUTOSEL : CODE_BYPEXIT;
      default: begin
        // The fourth write is a second unlock only for the erase
        if (idx == 3'h0 || (idx == 3'h3 && op == OP_ERASE)) begin
          ca = UNLOCK1_ADDR;
          cd = CODE_UNLOCK1;
        end else if (idx == 3'h1 || idx == 3'h4) begin
          ca = UNLOCK2_ADDR;
          cd = CODE_UNLOCK2;
        end else begin
          ca = UNLOCK1_ADDR;
          case (op)
            OP_RESET3:  cd = CODE_RESET;
            OP_AUTOSEL: cd = CODE_AUTOSEL;
            OP_BYPASS:  cd = CODE_BYPASS;
            OP_ERASE:   cd = (idx == 3'h2) ? CODE_ERASE1 : CODE_ERASE2;
            OP_PROGRAM: begin
              if (idx == 3'h2) cd = CODE_PROGRAM;
              else use_tgt = 1'b1;
            end
            default:    cd = CODE_RESET;
          endcase
        end
      end
    endcase
    // Upper address bits are left low on command writes
    if (use_tgt) return {ta, td};
    return {{(ADDR_W-CMD_ADDR_W){1'b0}}, ca, cd};
  endfunction : step_word

  assign cur_word  = step_word(op_q, step_q, tgt_addr_q, tgt_data_q);
  assign last_step = (step_q == cmd_len(op_q) - 3'h1);
  assign prog_type = op_q inside {OP_PROGRAM, OP_BYP_PROG, OP_ERASE};
  assign toggled   = bus_i.rdata[TOGGLE_BIT] != prev_q[TOGGLE_BIT];
  // Bypass mode only takes its own two commands and Read/Reset
  assign refused   = bypass_q
    ? !(cmd_op inside {OP_READ, OP_RESET, OP_BYP_PROG, OP_BYP_EXIT})
    : (cmd_op inside {OP_BYP_PROG, OP_BYP_EXIT});
  // Only a Read/Reset may interrupt, and only an erase
  assign abort_take = (state_q == S_POLL_ISSUE) && (op_q == OP_ERASE) &&
                      cmd_valid && (cmd_op == OP_RESET);

  // Command sequencing, status polling and error recovery
  always_comb begin
    state_d     = state_q;
    op_d        = op_q;
    step_d      = step_q;
    tgt_addr_d  = tgt_addr_q;
    tgt_data_d  = tgt_data_q;
    prev_d      = prev_q;
    poll_n_d    = poll_n_q;
    cnt_d       = cnt_q;
    bypass_d    = bypass_q;
    idm_d       = idm_q;
    abort_d     = abort_q;
    fail_d      = fail_q;
    rsp_valid_d = 1'b0;
    rsp_err_d   = rsp_err_q;
    rsp_data_d  = rsp_data_q;
    cmd_ready   = 1'b0;
    bus_i.req   = 1'b0;
    bus_i.wr    = (op_q != OP_READ);
    bus_i.addr  = cur_word[ADDR_W+7:8];
    bus_i.wdata = cur_word[7:0];
    case (state_q)
      S_IDLE: begin
        cmd_ready = 1'b1;
        if (cmd_valid) begin
          op_d       = cmd_op;
          tgt_addr_d = cmd_addr;
          tgt_data_d = cmd_data;
          step_d     = 3'h0;
          rsp_err_d  = refused;
          rsp_valid_d = refused;
          if (!refused) state_d = S_ISSUE;
        end
      end
      S_ISSUE: begin
        bus_i.req = 1'b1;
        state_d   = S_WAIT;
      end
      S_WAIT: begin
        if (bus_i.done) begin
          if (op_q == OP_READ) begin
            rsp_data_d  = bus_i.rdata;
            rsp_valid_d = 1'b1;
            state_d     = S_IDLE;
          end else if (!last_step) begin
            step_d  = step_q + 3'h1;
            state_d = S_ISSUE;
          end else begin
            // Mode tracking; bypass survives a Read/Reset
            idm_d = (op_q == OP_AUTOSEL);
            if (op_q == OP_BYPASS) bypass_d = 1'b1;
            if (op_q == OP_BYP_EXIT) bypass_d = 1'b0;
            poll_n_d = 2'h0;
            if (prog_type) begin
              state_d = S_POLL_ISSUE;
            end else if (abort_q) begin
              cnt_d   = 9'(ABORT_CYC - 1);
              state_d = S_ABORT;
            end else begin
              rsp_valid_d = 1'b1;
              rsp_err_d   = fail_q;
              fail_d      = 1'b0;
              state_d     = S_IDLE;
            end
          end
        end
      end
      S_POLL_ISSUE: begin
        // Any address answers with the status word while busy
        cmd_ready = abort_take;
        bus_i.wr  = 1'b0;
        bus_i.addr = tgt_addr_q;
        if (abort_take) begin
          op_d    = OP_RESET;
          step_d  = 3'h0;
          abort_d = 1'b1;
          state_d = S_ISSUE;
        end else begin
          bus_i.req = 1'b1;
          state_d   = S_POLL_WAIT;
        end
      end
      S_POLL_WAIT: begin
        if (bus_i.done) begin
          prev_d  = bus_i.rdata;
          state_d = S_POLL_ISSUE;
          if (poll_n_q == 2'h0 || poll_n_q == 2'h2) begin
            poll_n_d = poll_n_q + 2'h1;
          end else if (!toggled) begin
            rsp_data_d  = bus_i.rdata;
            rsp_valid_d = 1'b1;
            rsp_err_d   = 1'b0;
            state_d     = S_IDLE;
          end else if (poll_n_q == 2'h1) begin
            if (bus_i.rdata[ERROR_BIT]) poll_n_d = 2'h2;
          end else begin
            // Still toggling after the error bit: failed store
            rsp_data_d = bus_i.rdata;
            fail_d  = 1'b1;
            op_d    = OP_RESET;
            step_d  = 3'h0;
            state_d = S_ISSUE;
          end
        end
      end
      S_ABORT: begin
        // Array is left invalid, so the abort reports an error
        if (cnt_q == 9'h000) begin
          abort_d     = 1'b0;
          rsp_valid_d = 1'b1;
          rsp_err_d   = 1'b1;
          state_d     = S_IDLE;
        end else begin
          cnt_d = cnt_q - 9'h001;
        end
      end
      default: state_d = S_IDLE;
    endcase
  end

  // Controller registers
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_q     <= S_IDLE;
      op_q        <= OP_READ;
      step_q      <= 3'h0;
      tgt_addr_q  <= '0;
      tgt_data_q  <= 8'h00;
      prev_q      <= 8'h00;
      poll_n_q    <= 2'h0;
      cnt_q       <= 9'h000;
      bypass_q    <= 1'b0;
      idm_q       <= 1'b0;
      abort_q     <= 1'b0;
      fail_q      <= 1'b0;
      rsp_valid_q <= 1'b0;
      rsp_err_q   <= 1'b0;
      rsp_data_q  <= 8'h00;
    end else begin
      state_q     <= state_d;
      op_q        <= op_d;
      step_q      <= step_d;
      tgt_addr_q  <= tgt_addr_d;
      tgt_data_q  <= tgt_data_d;
      prev_q      <= prev_d;
      poll_n_q    <= poll_n_d;
      cnt_q       <= cnt_d;
      bypass_q    <= bypass_d;
      idm_q       <= idm_d;
      abort_q     <= abort_d;
      fail_q      <= fail_d;
      rsp_valid_q <= rsp_valid_d;
      rsp_err_q   <= rsp_err_d;
      rsp_data_q  <= rsp_data_d;
    end
  end

  assign rsp_valid   = rsp_valid_q;
  assign rsp_data    = rsp_data_q;
  assign rsp_err     = rsp_err_q;
  assign busy        = (state_q != S_IDLE);
  assign bypass_mode = bypass_q;
  assign id_mode     = idm_q;

  sequence s_reset_write;
    bus_i.req && bus_i.wr && bus_i.wdata == CODE_RESET;
  endsequence

  a_busy_no_cmd: assert property (@(posedge core_clk) disable iff (!rstn)
    state_q inside {S_POLL_ISSUE, S_POLL_WAIT} && op_q != OP_ERASE
    |-> !cmd_ready) else $error("command taken during program");
  a_fail_resets: assert property (@(posedge core_clk) disable iff (!rstn)
    $rose(fail_q) |-> s_reset_write)
    else $error("no reset write after failure");
  a_bypass_kept: assert property (@(posedge core_clk) disable iff (!rstn)
    fail_q && !$rose(fail_q) |-> $stable(bypass_q))
    else $error("recovery reset changed bypass mode");
  a_abort_end: assert property (@(posedge core_clk) disable iff (!rstn)
    state_q == S_ABORT && cnt_q == 9'h000 |=> rsp_valid && rsp_err && !busy)
    else $error("abort wait did not end with error");
  a_prog_target: assert property (@(posedge core_clk) disable iff (!rstn)
    bus_i.req && bus_i.wr && op_q == OP_PROGRAM && step_q == 3'h3
    |-> bus_i.addr == tgt_addr_q && bus_i.wdata == tgt_data_q)
    else $error("program write not at target");
  a_unlock_first: assert property (@(posedge core_clk) disable iff (!rstn)
    bus_i.req && step_q == 3'h0 &&
    op_q inside {OP_AUTOSEL, OP_BYPASS, OP_ERASE, OP_PROGRAM}
    |-> bus_i.addr == ADDR_W'(UNLOCK1_ADDR) && bus_i.wdata == CODE_UNLOCK1)
    else $error("unlock write wrong");
endmodule : flash_host

// *** verilog/flash_host_pkg.sv ***
package flash_host_pkg;

  // Bus timing at the 40 ns core clock
  localparam int CLK_PERIOD_NS = 40;
  localparam int T_WP_NS       = 60;    // Write strobe low time
  localparam int T_ACC_NS      = 45;    // Address to read data valid
  localparam int T_ABORT_NS    = 10000; // Erase abort after Read/Reset

  // Least times round up, never below one cycle
  function automatic int min_cycles(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : min_cycles

  localparam int WP_CYC    = min_cycles(T_WP_NS);
  localparam int ACC_CYC   = min_cycles(T_ACC_NS);
  localparam int ABORT_CYC = min_cycles(T_ABORT_NS);

  localparam int DATA_W     = 8;
  localparam int CMD_ADDR_W = 11; // command_address_bits

  // Command addresses and codes
  localparam logic [10:0] UNLOCK1_ADDR = 11'h555;
  localparam logic [10:0] UNLOCK2_ADDR = 11'h2AA;
  localparam logic [7:0]  CODE_UNLOCK1 = 8'hAA;
  localparam logic [7:0]  CODE_UNLOCK2 = 8'h55;
  localparam logic [7:0]  CODE_RESET   = 8'hF0;
  localparam logic [7:0]  CODE_AUTOSEL = 8'h90;
  localparam logic [7:0]  CODE_PROGRAM = 8'hA0;
  localparam logic [7:0]  CODE_BYPASS  = 8'h20;
  localparam logic [7:0]  CODE_BYPEXIT = 8'h00;
  localparam logic [7:0]  CODE_ERASE1  = 8'h80;
  localparam logic [7:0]  CODE_ERASE2  = 8'h10;

  // Status word bit positions
  localparam int POLL_BIT   = 7;
  localparam int TOGGLE_BIT = 6;
  localparam int ERROR_BIT  = 5;

  typedef enum logic [3:0] {
    OP_READ, OP_RESET, OP_RESET3, OP_AUTOSEL, OP_PROGRAM,
    OP_BYPASS, OP_BYP_PROG, OP_BYP_EXIT, OP_ERASE
  } op_e;

  // Number of bus cycles in each command; a read is a single read cycle
  function automatic logic [2:0] cmd_len(input op_e op);
    case (op)
      OP_READ, OP_RESET:         return 3'h1;
      OP_BYP_PROG, OP_BYP_EXIT:  return 3'h2;
      OP_PROGRAM:                return 3'h4;
      OP_ERASE:                  return 3'h6;
      default:                   return 3'h3;
    endcase
  endfunction : cmd_len

endpackage : flash_host_pkg
